// File: hdl/narrow_ports_defs.vh
// Purpose: offsets, widths and reset values for the narrow two-port block
// Assumes: byte-wide register port, printed offsets are byte addresses
// Notes: direction register offsets are chosen locally
`ifndef NARROW_PORTS_DEFS_VH
`define NARROW_PORTS_DEFS_VH

`define ADDR_W 8
`define DATA_W 8
`define G_WIDTH 3
`define H_WIDTH 2
`define KEY_WIDTH 5
`define KEY_G_LSB 0
`define KEY_H_LSB 3
`define OFF_G_LATCH 8'h0a
`define OFF_H_LATCH 8'h0b
`define OFF_G_DIR 8'h0e
`define OFF_H_DIR 8'h0f
`define G_DIR_RESET 3'h0
`define H_DIR_RESET 2'h0
`define READ_UNMAPPED 8'h00

`endif

// File: hdl/pin_port_slice.v
// Purpose: one narrow i/o port: latch, direction, pin sync, read mux
// Assumes: pins are asynchronous to clock
// Notes: latch has no reset value; direction clears on reset
`timescale 1ns/1ps
module pin_port_slice #(
  parameter WIDTH = 3
) (
  input wire clock,
  input wire srst,
  input wire latch_we,
  input wire dir_we,
  input wire [WIDTH-1:0] wdata,
  input wire [WIDTH-1:0] key_enable,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_out,
  output reg [WIDTH-1:0] pin_oe,
  output wire [WIDTH-1:0] latch_value,
  output wire [WIDTH-1:0] dir_value,
  output wire [WIDTH-1:0] data_read
);
  reg [WIDTH-1:0] latch_reg;
  reg [WIDTH-1:0] dir_reg;
  reg [WIDTH-1:0] pin_meta_reg;
  reg [WIDTH-1:0] pin_sync_reg;
  genvar i;

  // latch written whatever the direction; reset leaves it alone
  always @(posedge clock) begin
    if (latch_we) begin
      latch_reg <= wdata;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      dir_reg <= {WIDTH{1'b0}};
    end else if (dir_we) begin
      dir_reg <= wdata;
    end
  end

  always @(posedge clock) begin
    pin_meta_reg <= pin_in;
    pin_sync_reg <= pin_meta_reg;
  end

  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // key input enable wins over the direction bit
      always @(posedge clock) begin
        if (srst) begin
          pin_oe[i] <= 1'b0;
          pin_out[i] <= 1'b0;
        end else begin
          pin_oe[i] <= dir_reg[i] & ~key_enable[i];
          pin_out[i] <= latch_reg[i];
        end
      end
      // read mux follows direction only, not the key enable
      assign data_read[i] = dir_reg[i] ? latch_reg[i] : pin_sync_reg[i];
    end
  endgenerate

  assign latch_value = latch_reg;
  assign dir_value = dir_reg;
endmodule // pin_port_slice

// File: hdl/narrow_gpio_ports_g_h.v
// Purpose: three-bit and two-bit general-purpose ports shared with key wakeup
// Assumes: single 50 MHz clock, synchronous active-high reset
// Notes: read data valid one cycle after the read strobe only
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "narrow_ports_defs.vh"

// Operation
// [RQ1] three-bit port driver on when direction bit is one
// [RQ2] reset clears three-bit port direction bits
// [RQ3] three-bit data read gives latch for outputs, pin for inputs
// [RQ4] three-bit latch writable regardless of direction
// [RQ5] latch write on an input pin changes neither pin nor readback
// [RQ6] software loads latch before setting direction to output
// [RQ7] two-bit port has two latches, pins shared with key wakeup
// [RQ8] reset leaves two-bit latch contents unchanged
// [RQ9] key wakeup enables four and three make two-bit pins interrupt inputs; wakeup unit gets the latch, not the pin, where direction is one
// [RQ10] two-bit port driver on when direction bit is one
// [RQ11] reset clears two-bit port direction bits
// [RQ12] two-bit data read gives latch or pin; latch always writable
// [RQ13] software loads two-bit latch before enabling output
// [RQ14] three-bit port has three latches shared with key wakeup
// [RQ15] key wakeup enable overrides three-bit direction bit; code overrides it for the driver only, read-back still follows direction
// [RQ16] unimplemented upper bits read zero, writes ignored
// [RQ17] key wakeup enable overrides two-bit direction bit; code overrides it for the driver only, read-back still follows direction
module narrow_gpio_ports_g_h (
  input wire clock,
  input wire srst,
  input wire [`ADDR_W-1:0] addr,
  input wire [`DATA_W-1:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [`DATA_W-1:0] rdata,
  input wire [`KEY_WIDTH-1:0] key_wakeup_enable,
  input wire [`G_WIDTH-1:0] three_bit_port_pin_in,
  output wire [`G_WIDTH-1:0] three_bit_port_pin_out,
  output wire [`G_WIDTH-1:0] three_bit_port_pin_oe,
  input wire [`H_WIDTH-1:0] two_bit_port_pin_in,
  output wire [`H_WIDTH-1:0] two_bit_port_pin_out,
  output wire [`H_WIDTH-1:0] two_bit_port_pin_oe,
  output reg [`KEY_WIDTH-1:0] key_wakeup_pin_level
);
  wire g_latch_we;
  wire g_dir_we;
  wire h_latch_we;
  wire h_dir_we;
  wire [`G_WIDTH-1:0] g_latch;
  wire [`G_WIDTH-1:0] g_dir;
  wire [`G_WIDTH-1:0] g_read;
  wire [`H_WIDTH-1:0] h_latch;
  wire [`H_WIDTH-1:0] h_dir;
  wire [`H_WIDTH-1:0] h_read;
  reg [`DATA_W-1:0] rdata_next;

  // [RQ4] latch writes always taken
  assign g_latch_we = wr_stb && (addr == `OFF_G_LATCH);
  assign g_dir_we = wr_stb && (addr == `OFF_G_DIR);
  // [RQ12] latch writes always taken
  assign h_latch_we = wr_stb && (addr == `OFF_H_LATCH);
  assign h_dir_we = wr_stb && (addr == `OFF_H_DIR);

  // [RQ1] [RQ2] [RQ5] [RQ14] [RQ15] three-bit port pins
  pin_port_slice #(
    .WIDTH(`G_WIDTH)
  ) u_three_bit (
    .clock(clock),
    .srst(srst),
    .latch_we(g_latch_we),
    .dir_we(g_dir_we),
    .wdata(wdata[`G_WIDTH-1:0]),
    .key_enable(key_wakeup_enable[`KEY_G_LSB +: `G_WIDTH]),
    .pin_in(three_bit_port_pin_in),
    .pin_out(three_bit_port_pin_out),
    .pin_oe(three_bit_port_pin_oe),
    .latch_value(g_latch),
    .dir_value(g_dir),
    .data_read(g_read)
  );

  // [RQ7] [RQ8] [RQ9] [RQ10] [RQ11] [RQ17] two-bit port pins
  pin_port_slice #(
    .WIDTH(`H_WIDTH)
  ) u_two_bit (
    .clock(clock),
    .srst(srst),
    .latch_we(h_latch_we),
    .dir_we(h_dir_we),
    .wdata(wdata[`H_WIDTH-1:0]),
    .key_enable(key_wakeup_enable[`KEY_H_LSB +: `H_WIDTH]),
    .pin_in(two_bit_port_pin_in),
    .pin_out(two_bit_port_pin_out),
    .pin_oe(two_bit_port_pin_oe),
    .latch_value(h_latch),
    .dir_value(h_dir),
    .data_read(h_read)
  );

  // [RQ3] [RQ12] [RQ16] read mux, upper bits zero
  always @* begin
    rdata_next = `READ_UNMAPPED;
    if (addr == `OFF_G_LATCH) begin
      rdata_next = {{(`DATA_W-`G_WIDTH){1'b0}}, g_read};
    end else if (addr == `OFF_H_LATCH) begin
      rdata_next = {{(`DATA_W-`H_WIDTH){1'b0}}, h_read};
    end else if (addr == `OFF_G_DIR) begin
      rdata_next = {{(`DATA_W-`G_WIDTH){1'b0}}, g_dir};
    end else if (addr == `OFF_H_DIR) begin
      rdata_next = {{(`DATA_W-`H_WIDTH){1'b0}}, h_dir};
    end
  end

  // read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (srst) begin
      rdata <= {`DATA_W{1'b0}};
    end else if (rd_stb) begin
      rdata <= rdata_next;
    end else begin
      rdata <= {`DATA_W{1'b0}};
    end
  end

  // [RQ9] read-back levels (latch where direction is one, synced pin otherwise) handed to the key wakeup unit
  always @(posedge clock) begin
    if (srst) begin
      key_wakeup_pin_level <= {`KEY_WIDTH{1'b0}};
    end else begin
      key_wakeup_pin_level <= {h_read & ~h_dir | h_latch & h_dir,
                               g_read & ~g_dir | g_latch & g_dir};
    end
  end
endmodule // narrow_gpio_ports_g_h

// File: bench/pin_far_end.sv
// Purpose: pin level model for both narrow ports
// Assumes: no pulls; ext is the outside driver
// Notes: a driven bit wins over ext
`timescale 1ns/1ps
module pin_far_end (
  input wire [2:0] three_bit_port_pin_out,
  input wire [2:0] three_bit_port_pin_oe,
  input wire [1:0] two_bit_port_pin_out,
  input wire [1:0] two_bit_port_pin_oe,
  input wire [4:0] ext,
  output wire [2:0] three_bit_port_pin_in,
  output wire [1:0] two_bit_port_pin_in
);
  assign three_bit_port_pin_in = three_bit_port_pin_oe & three_bit_port_pin_out
    | ~three_bit_port_pin_oe & ext[2:0];
  assign two_bit_port_pin_in = two_bit_port_pin_oe & two_bit_port_pin_out
    | ~two_bit_port_pin_oe & ext[4:3];
endmodule // pin_far_end

// File: bench/narrow_gpio_ports_g_h_sva.sv
// Purpose: port checks for the narrow ports
// Assumes: direction offsets 0x0e and 0x0f
// Notes: shadows follow register writes
`timescale 1ns/1ps
module narrow_gpio_ports_g_h_sva (
  input wire clock,
  input wire srst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] rdata,
  input wire [4:0] key_wakeup_enable,
  input wire [2:0] three_bit_port_pin_out,
  input wire [2:0] three_bit_port_pin_oe,
  input wire [1:0] two_bit_port_pin_oe
);
  reg [2:0] gd_reg, gl_reg;
  reg [1:0] hd_reg, hl_reg;
  always @(posedge clock) begin
    if (wr_stb && addr == 8'h0a)
      gl_reg <= wdata[2:0];
    if (wr_stb && addr == 8'h0b)
      hl_reg <= wdata[1:0];
    if (srst)
      {gd_reg, hd_reg} <= 5'h00;
    else if (wr_stb && addr == 8'h0e)
      gd_reg <= wdata[2:0];
    else if (wr_stb && addr == 8'h0f)
      hd_reg <= wdata[1:0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_wr_g;
    wr_stb && addr == 8'h0a;
  endsequence
  a_g_oe_dir: assert property (three_bit_port_pin_oe ==
    $past(gd_reg & ~key_wakeup_enable[2:0])) else $error("g enable");
  a_h_oe_dir: assert property (two_bit_port_pin_oe ==
    $past(hd_reg & ~key_wakeup_enable[4:3])) else $error("h enable");
  a_g_out_latch: assert property (s_wr_g ##2 1 |->
    three_bit_port_pin_out == $past(wdata[2:0], 2)) else $error("g out");
  a_rd_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("idle read");
  a_rd_unmapped: assert property (rd_stb && addr[7:1] != 7'h05
    && addr[7:1] != 7'h07 |=> rdata == 8'h00) else $error("unmapped");
  a_h_dir_read: assert property (rd_stb && addr == 8'h0f |=>
    rdata == {6'h00, $past(hd_reg)}) else $error("h dir");
  a_g_read_out: assert property (rd_stb && addr == 8'h0a |=>
    (rdata & {5'h1f, $past(gd_reg)}) == {5'h00, $past(gd_reg & gl_reg)}) else $error("g rd");
  a_h_read_out: assert property (rd_stb && addr == 8'h0b |=>
    (rdata & {6'h3f, $past(hd_reg)}) == {6'h00, $past(hd_reg & hl_reg)}) else $error("h rd");
endmodule // narrow_gpio_ports_g_h_sva
bind narrow_gpio_ports_g_h narrow_gpio_ports_g_h_sva u_sva (.*);

// File: bench/narrow_gpio_ports_g_h_tb_top.sv
// Purpose: self-checking bench for the narrow ports
// Assumes: far side resolves the pins
// Notes: random mix plus reset corners
`timescale 1ns/1ps
module narrow_gpio_ports_g_h_tb_top;
  logic clock, srst, wr_stb, rd_stb;
  logic [7:0] addr, wdata, rdata;
  logic [4:0] key_wakeup_enable, ext, key_wakeup_pin_level;
  logic [2:0] three_bit_port_pin_in, three_bit_port_pin_out, three_bit_port_pin_oe, gd, gl;
  logic [1:0] two_bit_port_pin_in, two_bit_port_pin_out, two_bit_port_pin_oe, hd, hl;
  int failures, n_compared;
  narrow_gpio_ports_g_h u_dut (.*);
  pin_far_end u_far (.*);
  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  function [7:0] mix(input [2:0] dd, l, e);
    mix = {5'h00, (dd & l) | (~dd & e)};
  endfunction
  task chk(input [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input w, input [7:0] a, v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr_stb <= w;
    rd_stb <= !w;
    @(posedge clock);
    {wr_stb, rd_stb} <= 2'h0;
    @(negedge clock);
  endtask
  task test_done;
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    test_done;
  end
  initial begin
    {wr_stb, rd_stb, addr, wdata, key_wakeup_enable, ext} = 0;
    srst = 1;
    void'($urandom(99));
    repeat (6) @(posedge clock);
    srst <= 0;
    bus(0, 8'h0f, 8'h00);
    chk(rdata, 8'h00);
    chk({3'h0, three_bit_port_pin_oe, two_bit_port_pin_oe}, 8'h00);
    bus(1, 8'h0b, 8'h02);
    bus(1, 8'h0a, 8'h05);
    bus(1, 8'h0e, 8'h07);
    @(posedge clock);
    srst <= 1;
    repeat (3) @(posedge clock);
    srst <= 0;
    bus(0, 8'h0e, 8'h00);
    chk(rdata, 8'h00);
    chk({3'h0, three_bit_port_pin_oe, two_bit_port_pin_oe}, 8'h00);
    bus(1, 8'h0f, 8'h03);
    bus(0, 8'h0b, 8'h00);
    chk(rdata, 8'h02);
    bus(0, 8'h55, 8'h00);
    chk(rdata, 8'h00);
    for (int i = 0; i < 24; i++) begin
      {gd, hd, gl, hl} = 10'($urandom);
      if (i < 2)
        {gd, hd} = i ? 5'h00 : 5'h1f;
      @(posedge clock);
      key_wakeup_enable <= i < 2 ? 5'h00 : 5'($urandom);
      ext <= 5'($urandom);
      bus(1, 8'h0a, {5'($urandom), gl});
      bus(1, 8'h0b, {6'h2a, hl});
      bus(1, 8'h0e, {5'h1f, gd});
      bus(1, 8'h0f, {6'h3f, hd});
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk({3'h0, three_bit_port_pin_oe, two_bit_port_pin_oe},
        {3'h0, gd & ~key_wakeup_enable[2:0], hd & ~key_wakeup_enable[4:3]});
      chk({3'h0, three_bit_port_pin_out, two_bit_port_pin_out}, {3'h0, gl, hl});
      bus(0, 8'h0a, 8'h00);
      chk(rdata, mix(gd, gl, ext[2:0]));
      bus(0, 8'h0b, 8'h00);
      chk(rdata, mix({1'b0, hd}, {1'b0, hl}, {1'b0, ext[4:3]}));
      chk({3'h0, key_wakeup_pin_level},
        {3'h0, hd & hl | ~hd & ext[4:3], gd & gl | ~gd & ext[2:0]});
    end
    test_done;
  end
endmodule // narrow_gpio_ports_g_h_tb_top
